// ===== core/cmpctl_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
// Function
// - Code zero routes the ladder output to the selected comparator input.
// - Codes one to five route external inputs one to five.
// - Code six routes the internal bandgap reference.
// - Code seven routes the DAC output.
// - Positive select sits in control bits 10:8, resets to zero.
// - Negative select sits in control bits 13:11, same mapping, reset zero.
// - Edge select bits 4:3: 0 falling, 1 rising, 2 or 3 both.
// - Matching edges set sticky flag bit 23, which requests an interrupt.
// - Writing one to edge clear negates flag and interrupt request; a matching edge in the same cycle keeps the flag set.
// - Control bit 6 selects raw or bus-clock synchronized output.
// - Conditioned comparator output is offered for an external pin.
// - Raw output path works without the bus clock.
// - Read-only status bit shows the comparator output state.
// - Ladder tap selects one of 32 steps, ground to reference.
// - Ladder reference selects supply pin or dedicated reference pin.
// - Interrupt leaves only while enable bit 24 is set.
// - Edge clear at bit 20, status bit 21, flag bit 23.
// - Ladder: enable bit 0, tap bits 5:1, reference select bit 6.
module cmpctl_top
    import cmpctl_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic [DATA_W-1:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [DATA_W-1:0] bus_rdata_o,
    input wire logic cmp_raw_i,
    output logic [NUM_INPUTS-1:0] pos_route_o,
    output logic [NUM_INPUTS-1:0] neg_route_o,
    output logic ladder_enable_o,
    output logic [TAP_W-1:0] ladder_tap_value_o,
    output logic ladder_reference_select_o,
    output logic cmp_out_o,
    output logic comparator_output_pin_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [NUM_INPUTS-1:0] route_decode(input logic [SEL_W-1:0] sel);
        logic [NUM_INPUTS-1:0] hot;
        hot = '0;
        hot[sel] = 1'b1;
        return hot;
    endfunction : route_decode

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cmpctl_ctrl_t ctrl_r;
    cmpctl_ctrl_t ctrl_nxt;
    cmpctl_lad_t lad_r;
    cmpctl_lad_t lad_nxt;
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic flag_r;
    logic flag_nxt;
    logic irq_nxt;
    logic [DATA_W-1:0] rdata_nxt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic hit_ctrl = (bus_addr_i == OFS_COMPARATOR_CONTROL);
    wire logic hit_lad = (bus_addr_i == OFS_REFERENCE_LADDER_CONTROL);
    wire logic wr_ctrl = bus_wr_i & hit_ctrl;
    wire logic wr_lad = bus_wr_i & hit_lad;

    // Control register write
    // Reserved bits are simply not stored
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt.edge_select = bus_wdata_i[POS_EDGE_SEL_HI:POS_EDGE_SEL_LO];
            ctrl_nxt.output_sync_select = bus_wdata_i[POS_SYNC_SEL];
            ctrl_nxt.positive_input_select = bus_wdata_i[POS_PSEL_HI:POS_PSEL_LO];
            ctrl_nxt.negative_input_select = bus_wdata_i[POS_NSEL_HI:POS_NSEL_LO];
            ctrl_nxt.edge_flag_clear = bus_wdata_i[POS_EDGE_CLR];
            ctrl_nxt.interrupt_enable = bus_wdata_i[POS_INT_EN];
        end
    end

    always_comb begin
        lad_nxt = lad_r;
        if (wr_lad) begin
            lad_nxt.ladder_enable = bus_wdata_i[POS_LAD_EN];
            lad_nxt.ladder_tap_value = bus_wdata_i[POS_LAD_TAP_HI:POS_LAD_TAP_LO];
            lad_nxt.ladder_reference_select = bus_wdata_i[POS_LAD_REF];
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    // Compare with previous
    wire logic rise = sync2_r & ~prev_r;
    wire logic fall = ~sync2_r & prev_r;
    wire logic edge_hit = (ctrl_r.edge_select == EDGE_FALL) ? fall :
                          (ctrl_r.edge_select == EDGE_RISE) ? rise : (rise | fall);
    // Clear acts on the write of a one; holding the bit high does not stop a later edge setting the flag
    wire logic clr_req = wr_ctrl & bus_wdata_i[POS_EDGE_CLR];

    always_comb begin
        flag_nxt = flag_r;
        if (clr_req) begin
            flag_nxt = 1'b0;
        end
        if (edge_hit) begin
            flag_nxt = 1'b1;
        end
    end

    assign irq_nxt = flag_nxt & ctrl_nxt.interrupt_enable;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Live output status
    always_comb begin
        rdata_nxt = '0;
        if (bus_rd_i && hit_ctrl) begin
            rdata_nxt[POS_EDGE_SEL_HI:POS_EDGE_SEL_LO] = ctrl_r.edge_select;
            rdata_nxt[POS_SYNC_SEL] = ctrl_r.output_sync_select;
            rdata_nxt[POS_PSEL_HI:POS_PSEL_LO] = ctrl_r.positive_input_select;
            rdata_nxt[POS_NSEL_HI:POS_NSEL_LO] = ctrl_r.negative_input_select;
            rdata_nxt[POS_EDGE_CLR] = ctrl_r.edge_flag_clear;
            rdata_nxt[POS_OUT_STATUS] = sync2_r;
            rdata_nxt[POS_EDGE_FLAG] = flag_r;
            rdata_nxt[POS_INT_EN] = ctrl_r.interrupt_enable;
        end else if (bus_rd_i && hit_lad) begin
            rdata_nxt[POS_LAD_EN] = lad_r.ladder_enable;
            rdata_nxt[POS_LAD_TAP_HI:POS_LAD_TAP_LO] = lad_r.ladder_tap_value;
            rdata_nxt[POS_LAD_REF] = lad_r.ladder_reference_select;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= CTRL_RST;
            lad_r <= LAD_RST;
            flag_r <= 1'b0;
            irq_o <= 1'b0;
            bus_rdata_o <= '0;
        end else if (clk_en_i) begin
            ctrl_r <= ctrl_nxt;
            lad_r <= lad_nxt;
            flag_r <= flag_nxt;
            irq_o <= irq_nxt;
            bus_rdata_o <= rdata_nxt;
        end
    end

    // Two-stage synchronizer; first stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (clk_en_i) begin
            sync1_r <= cmp_raw_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // ------------------------------------------------------------
    // Analog control outputs
    // ------------------------------------------------------------
    // Input routing
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pos_route_o <= route_decode(SEL_LADDER);
            neg_route_o <= route_decode(SEL_LADDER);
        end else if (clk_en_i) begin
            pos_route_o <= route_decode(ctrl_nxt.positive_input_select);
            neg_route_o <= route_decode(ctrl_nxt.negative_input_select);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ladder_enable_o <= 1'b0;
            ladder_tap_value_o <= '0;
            ladder_reference_select_o <= REF_SUPPLY;
        end else if (clk_en_i) begin
            ladder_enable_o <= lad_nxt.ladder_enable;
            ladder_tap_value_o <= lad_nxt.ladder_tap_value;
            ladder_reference_select_o <= lad_nxt.ladder_reference_select;
        end
    end

    // ------------------------------------------------------------
    // Conditioned output
    // ------------------------------------------------------------
    // Raw path stays combinational so it survives a stopped clock
    // Raw or synchronized
    assign cmp_out_o = ctrl_r.output_sync_select ? sync2_r : cmp_raw_i;
    assign comparator_output_pin_o = cmp_out_o;

endmodule : cmpctl_top

// ===== core/cmpctl_pkg.sv
package cmpctl_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_COMPARATOR_CONTROL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_REFERENCE_LADDER_CONTROL = 12'h004;
    localparam logic [DATA_W-1:0] RST_COMPARATOR_CONTROL = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_REFERENCE_LADDER_CONTROL = 32'h0000_0000;

    // ------------------------------------------------------------
    // Comparator control fields
    // ------------------------------------------------------------
    localparam int POS_EDGE_SEL_LO = 3;
    localparam int POS_EDGE_SEL_HI = 4;
    localparam int POS_SYNC_SEL = 6;
    localparam int POS_PSEL_LO = 8;
    localparam int POS_PSEL_HI = 10;
    localparam int POS_NSEL_LO = 11;
    localparam int POS_NSEL_HI = 13;
    localparam int POS_EDGE_CLR = 20;
    localparam int POS_OUT_STATUS = 21;
    localparam int POS_EDGE_FLAG = 23;
    localparam int POS_INT_EN = 24;

    // ------------------------------------------------------------
    // Ladder fields
    // ------------------------------------------------------------
    localparam int POS_LAD_EN = 0;
    localparam int POS_LAD_TAP_LO = 1;
    localparam int POS_LAD_TAP_HI = 5;
    localparam int POS_LAD_REF = 6;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam int SEL_W = 3;
    localparam int NUM_INPUTS = 8;
    localparam int TAP_W = 5;
    localparam logic [SEL_W-1:0] SEL_LADDER = 3'h0;
    localparam logic [SEL_W-1:0] SEL_EXT_FIRST = 3'h1;
    localparam logic [SEL_W-1:0] SEL_EXT_LAST = 3'h5;
    localparam logic [SEL_W-1:0] SEL_BANDGAP = 3'h6;
    localparam logic [SEL_W-1:0] SEL_DAC = 3'h7;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic REF_SUPPLY = 1'h0;
    localparam logic REF_PIN = 1'h1;

    typedef struct packed {
        logic [1:0] edge_select;
        logic output_sync_select;
        logic [SEL_W-1:0] positive_input_select;
        logic [SEL_W-1:0] negative_input_select;
        logic edge_flag_clear;
        logic interrupt_enable;
    } cmpctl_ctrl_t;

    typedef struct packed {
        logic ladder_enable;
        logic [TAP_W-1:0] ladder_tap_value;
        logic ladder_reference_select;
    } cmpctl_lad_t;

    localparam cmpctl_ctrl_t CTRL_RST = '0;
    localparam cmpctl_lad_t LAD_RST = '0;

endpackage : cmpctl_pkg

// ===== dv/cmpctl_checker.sv
`timescale 1ns/100ps
module cmpctl_checker
    import cmpctl_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic [DATA_W-1:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [DATA_W-1:0] bus_rdata_o,
    input wire logic cmp_raw_i,
    input wire logic [NUM_INPUTS-1:0] pos_route_o,
    input wire logic [NUM_INPUTS-1:0] neg_route_o,
    input wire logic [TAP_W-1:0] ladder_tap_value_o,
    input wire logic cmp_out_o,
    input wire logic comparator_output_pin_o,
    input wire logic irq_o
);
    // ----------------
    // Properties
    // ----------------
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    wire wr_ctl = bus_wr_i && clk_en_i && bus_addr_i == OFS_COMPARATOR_CONTROL;
    wire wr_lad = bus_wr_i && clk_en_i && bus_addr_i == OFS_REFERENCE_LADDER_CONTROL;
    wire rd_ctl = bus_rd_i && clk_en_i && bus_addr_i == OFS_COMPARATOR_CONTROL;
    property p_pos_route; wr_ctl |=> pos_route_o == 8'h01 << $past(bus_wdata_i[10:8]); endproperty
    property p_neg_route; wr_ctl |=> neg_route_o == 8'h01 << $past(bus_wdata_i[13:11]); endproperty
    property p_tap; wr_lad |=> ladder_tap_value_o == $past(bus_wdata_i[5:1]); endproperty
    property p_pin; comparator_output_pin_o == cmp_out_o; endproperty
    property p_rd_idle; !bus_rd_i && clk_en_i |=> bus_rdata_o == 32'h0; endproperty
    // Read status lags the pin by three cycles: the two synchronizer stages and the read data register
    property p_status; rd_ctl && $past(clk_en_i) |=> bus_rdata_o[21] == $past(cmp_raw_i, 3); endproperty
    property p_irq_off; wr_ctl && !bus_wdata_i[24] |=> !irq_o; endproperty
    property p_clear;
        wr_ctl && bus_wdata_i[20] && $past(clk_en_i) && $past(cmp_raw_i, 2) == $past(cmp_raw_i, 3) |=> !irq_o;
    endproperty
    property p_sticky; irq_o && !wr_ctl |=> irq_o; endproperty
    a_pos_route: assert property (p_pos_route) else $error("positive route wrong");
    a_neg_route: assert property (p_neg_route) else $error("negative route wrong");
    a_tap: assert property (p_tap) else $error("ladder tap wrong");
    a_pin: assert property (p_pin) else $error("pin differs from output");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_status: assert property (p_status) else $error("status bit wrong");
    a_irq_off: assert property (p_irq_off) else $error("irq without enable");
    a_clear: assert property (p_clear) else $error("clear did not drop irq");
    a_sticky: assert property (p_sticky) else $error("irq dropped by itself");
    c_irq: cover property ($rose(irq_o));
    c_clear: cover property (wr_ctl && bus_wdata_i[20] && irq_o);
    c_lad: cover property (wr_lad);
endmodule : cmpctl_checker

bind cmpctl_top cmpctl_checker cmpctl_checker_i (.*);

// ===== dv/cmpctl_analog_model.sv
`timescale 1ns/100ps
module cmpctl_analog_model
    import cmpctl_pkg::*;
(
    input wire logic [NUM_INPUTS-1:0] pos_route_i,
    input wire logic [NUM_INPUTS-1:0] neg_route_i,
    input wire logic ladder_enable_i,
    input wire logic [TAP_W-1:0] ladder_tap_value_i,
    input wire logic ladder_reference_select_i,
    input wire logic [39:0] external_inputs_i,
    input wire logic [7:0] dac_output_i,
    output logic cmp_raw_o
);
    // ----------------
    // Analog levels
    // ----------------
    localparam logic [7:0] BANDGAP_LVL = 8'h40;
    logic [8:0] lvl [NUM_INPUTS];
    logic [8:0] vp;
    logic [8:0] vn;
    always_comb begin
        lvl[0] = ladder_enable_i ? {4'h0, ladder_tap_value_i} << (ladder_reference_select_i ? 2 : 3) : 9'h0;
        for (int k = 1; k < 6; k++) begin
            lvl[k] = {1'b0, external_inputs_i[8*k-8 +: 8]};
        end
        lvl[6] = {1'b0, BANDGAP_LVL};
        lvl[7] = {1'b0, dac_output_i};
        vp = 9'h0;
        vn = 9'h0;
        for (int k = 0; k < NUM_INPUTS; k++) begin
            if (pos_route_i[k]) vp = lvl[k];
            if (neg_route_i[k]) vn = lvl[k];
        end
    end
    assign cmp_raw_o = vp > vn;
endmodule : cmpctl_analog_model

// ===== dv/cmpctl_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module cmpctl_bench;
    import cmpctl_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, en = 1'b1, wr = 1'b0, rd = 1'b0, ie;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wd = '0, rd_data;
    logic raw, len, lref, cout, pin, irq;
    logic [NUM_INPUTS-1:0] pr, nr;
    logic [TAP_W-1:0] tap;
    logic [39:0] ext = 40'h50_40_30_20_10;
    logic [7:0] dac = 8'h28;
    logic [8:0] lv [NUM_INPUTS] = '{9'h0, 9'h10, 9'h20, 9'h30, 9'h40, 9'h50, 9'h40, 9'h28};
    logic [31:0] lad_v [3] = '{32'h01, 32'h7f, 32'h7e};
    int n_fail = 0;
    int check_count = 0;
    cmpctl_top cmpctl_top_i (.clk_sys_i(clk), .rst_b_i(rst_b), .clk_en_i(en), .bus_addr_i(addr),
        .bus_wdata_i(wd), .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rd_data), .cmp_raw_i(raw),
        .pos_route_o(pr), .neg_route_o(nr), .ladder_enable_o(len), .ladder_tap_value_o(tap),
        .ladder_reference_select_o(lref), .cmp_out_o(cout), .comparator_output_pin_o(pin), .irq_o(irq));
    cmpctl_analog_model cmpctl_analog_model_i (.pos_route_i(pr), .neg_route_i(nr), .ladder_enable_i(len),
        .ladder_tap_value_i(tap), .ladder_reference_select_i(lref), .external_inputs_i(ext),
        .dac_output_i(dac), .cmp_raw_o(raw));
    // ----------------
    // Bus tasks
    // ----------------
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rd_data, e)
        @(posedge clk);
    endtask : rd_chk
    function automatic logic [31:0] ctl(input logic [1:0] es, input logic sy, input logic [2:0] p,
        input logic [2:0] n, input logic clr, input logic ie);
        return {7'h0, ie, 3'h0, clr, 6'h0, n, p, 1'h0, sy, 1'h0, es, 3'h0};
    endfunction : ctl
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    // ----------------
    // Tests
    // ----------------
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        `CHK(pr, 8'h01)
        rd_chk(OFS_COMPARATOR_CONTROL, RST_COMPARATOR_CONTROL);
        rd_chk(OFS_REFERENCE_LADDER_CONTROL, RST_REFERENCE_LADDER_CONTROL);
        rd_chk(12'h008, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wr_reg(OFS_COMPARATOR_CONTROL, ctl(2'h0, 1'b0, c[2:0], 3'h7 - c[2:0], 1'b0, 1'b0));
            `CHK(pr, 8'h01 << c)
            `CHK(nr, 8'h80 >> c)
            `CHK(cout, lv[c] > lv[7 - c])
        end
        wr_reg(OFS_COMPARATOR_CONTROL, ctl(2'h0, 1'b0, 3'h0, 3'h1, 1'b0, 1'b0));
        for (int i = 0; i < 3; i++) begin
            wr_reg(OFS_REFERENCE_LADDER_CONTROL, lad_v[i]);
            repeat (3) @(posedge clk);
            `CHK(tap, lad_v[i][5:1])
            `CHK({len, lref}, {lad_v[i][0], lad_v[i][6]})
            `CHK(cout, i == 1)
            rd_chk(OFS_REFERENCE_LADDER_CONTROL, lad_v[i]);
        end
        for (int es = 0; es < 4; es++) begin
            ie = es != 2;
            wr_reg(OFS_COMPARATOR_CONTROL, ctl(es[1:0], 1'b0, 3'h1, 3'h2, 1'b1, ie));
            wr_reg(OFS_COMPARATOR_CONTROL, ctl(es[1:0], 1'b0, 3'h1, 3'h2, 1'b0, ie));
            ext[7:0] <= 8'h30;
            repeat (4) @(posedge clk);
            `CHK(irq, ie & (es != 0))
            rd_chk(OFS_COMPARATOR_CONTROL, ctl(es[1:0], 1'b0, 3'h1, 3'h2, 1'b0, ie)
                | {8'h0, es != 0, 1'b0, 1'b1, 21'h0});
            wr_reg(OFS_COMPARATOR_CONTROL, ctl(es[1:0], 1'b0, 3'h1, 3'h2, 1'b1, ie));
            `CHK(irq, 1'b0)
            wr_reg(OFS_COMPARATOR_CONTROL, ctl(es[1:0], 1'b0, 3'h1, 3'h2, 1'b0, ie));
            ext[7:0] <= 8'h10;
            repeat (4) @(posedge clk);
            `CHK(irq, ie & (es != 1))
        end
        wr_reg(OFS_COMPARATOR_CONTROL, ctl(2'h2, 1'b1, 3'h1, 3'h2, 1'b0, 1'b0));
        ext[7:0] <= 8'h30;
        @(posedge clk);
        #1;
        `CHK(cout, 1'b0)
        @(posedge clk);
        #1;
        `CHK({cout, pin}, 2'h3)
        @(posedge clk);
        // Accesses with the clock enable low must be lost
        en <= 1'b0;
        wr_reg(OFS_REFERENCE_LADDER_CONTROL, 32'h02);
        en <= 1'b1;
        rd_chk(OFS_REFERENCE_LADDER_CONTROL, 32'h7e);
        summarize;
    end
endmodule : cmpctl_bench
